// *** logic/multiframe_change_tracker.sv ***
// one framer's live loss state and its sticky change flag
module multiframe_change_tracker (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic loss_in,      // framer loss-of-multiframe level
    input  wire logic clear,        // read-clear of the flag, as seen in read data
    output logic      live,         // live loss state
    output logic      changed       // sticky entry or exit flag
);

    logic live_reg;      // registered loss state
    logic changed_reg;   // sticky change flag
    logic changed_next;  // next flag value
    logic edge_seen;     // entry or exit this cycle

    // both entry and exit mark a change; a new change beats a clear
    assign edge_seen    = live_reg ^ loss_in;
    assign changed_next = edge_seen | (changed_reg & ~clear);

    // state follows the framer every cycle, whatever the enables say
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            live_reg    <= 1'b0;
            changed_reg <= 1'b0;
        end else begin
            live_reg    <= loss_in;
            changed_reg <= changed_next;
        end
    end

    assign live    = live_reg;
    assign changed = changed_reg;

endmodule // multiframe_change_tracker

// *** logic/tributary_interrupt_aggregator.sv ***
module tributary_interrupt_aggregator (
    input  wire logic                              sys_clk,
    input  wire logic                              rst,
    // avalon-mm slave
    input  wire logic [trib_irq_pkg::ADDR_W-1:0]   address,
    input  wire logic                              read,
    input  wire logic                              write,
    input  wire logic [trib_irq_pkg::DATA_W-1:0]   writedata,
    input  wire logic [3:0]                        byteenable,
    output logic      [trib_irq_pkg::DATA_W-1:0]   readdata,
    output logic                                   waitrequest,
    // event sources from the slice processors, same clock
    input  wire logic [2:0]                        payload_proc_src_pending,
    input  wire logic [2:0]                        multiframe_loss_in,
    input  wire logic                              parity_mismatch,
    // byte streams, same clock
    input  wire logic [7:0]                        in_data,
    input  wire logic                              incoming_frame_marker,
    input  wire logic                              outgoing_frame_marker,
    input  wire logic                              out_slot_slice3,
    input  wire logic [7:0]                        processed_data,
    output logic      [7:0]                        out_data,
    // slice-three control and per-slice alignment loss
    output logic                                   slice3_hold_reset,
    output logic                                   slice3_reg_reset,
    output logic      [6:0]                        slice3_cfg,
    output logic      [2:0]                        multiframe_align_lost,
    // shared interrupt
    output logic                                   irq_out_n
);

    // ---------------- bus decode ----------------

    logic       ack_reg;          // high in the cycle a request is answered
    logic       access;           // any request present
    logic       accept;           // request taken at this edge
    logic       word_ok;          // address word aligned
    logic [7:0] reg_idx;          // register index from byte address
    logic       lane0;            // low byte lane written
    logic       wr_cfg;           // write to slice-three configuration
    logic       wr_en;            // write to interrupt enable register
    logic       wr_par;           // write to parity register reserved bits
    logic       wr_mst;           // write to master incoming configuration
    logic       rd_par_taken;     // parity register read completes
    logic       rd_capture;       // read data are loaded at this edge

    assign access      = read | write;
    assign waitrequest = access & ~ack_reg;   // one wait state on every access
    assign accept      = access & ack_reg;
    assign word_ok     = (address[1:0] == 2'h0);
    assign reg_idx     = address[trib_irq_pkg::ADDR_W-1:2];
    assign lane0       = byteenable[0];
    assign rd_capture  = read & ~ack_reg;

    // write strobes only at the accepting edge and only with lane zero
    assign wr_cfg = accept & write & lane0 & word_ok & (reg_idx == trib_irq_pkg::IDX_SLICE3_CFG);
    assign wr_en  = accept & write & lane0 & word_ok & (reg_idx == trib_irq_pkg::IDX_IRQ_ENABLE);
    assign wr_par = accept & write & lane0 & word_ok & (reg_idx == trib_irq_pkg::IDX_PARITY_LOM);
    assign wr_mst = accept & write & lane0 & word_ok & (reg_idx == trib_irq_pkg::IDX_MASTER_IN);
    assign rd_par_taken = accept & read & word_ok & (reg_idx == trib_irq_pkg::IDX_PARITY_LOM);

    // answer timing: request held, acknowledged one cycle later
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= access & ~ack_reg;
        end
    end

    // ---------------- control registers ----------------

    logic [7:0] slice3_cfg_reg;   // enable in bit seven, mode bits below
    logic [5:0] irq_en_reg;       // processor and multiframe enables
    logic [2:0] rsv_reg;          // reserved set-one bits
    logic [1:0] master_in_reg;    // concat mode and parity enable
    logic       slice_en;         // slice_processing_enable
    logic       slice_en_d_reg;   // enable one cycle ago, for the falling edge
    logic       concat_mode;      // incoming_concat_mode
    logic       parity_en;        // incoming_parity_irq_enable
    logic [2:0] pp_en;            // payload processor interrupt enables
    logic [2:0] lom_en;           // multiframe change interrupt enables

    assign slice_en    = slice3_cfg_reg[trib_irq_pkg::SLICE_EN_BIT];
    assign concat_mode = master_in_reg[trib_irq_pkg::CONCAT_BIT];
    assign parity_en   = master_in_reg[trib_irq_pkg::IPE_BIT];
    assign pp_en       = irq_en_reg[trib_irq_pkg::PP_LSB +: 3];
    assign lom_en      = irq_en_reg[trib_irq_pkg::LOM_LSB +: 3];

    // software-written configuration; only the low byte lane carries data
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            slice3_cfg_reg <= trib_irq_pkg::SLICE3_CFG_RST;
            irq_en_reg     <= trib_irq_pkg::IRQ_EN_RST;
            rsv_reg        <= trib_irq_pkg::RSV_RST;
            master_in_reg  <= trib_irq_pkg::MASTER_IN_RST;
        end else begin
            if (wr_cfg) begin
                slice3_cfg_reg <= writedata[7:0];
            end
            if (wr_en) begin
                irq_en_reg <= writedata[5:0];
            end
            if (wr_par) begin
                // hardware does not force these; software keeps them at one
                rsv_reg <= writedata[trib_irq_pkg::RSV_LSB +: 3];
            end
            if (wr_mst) begin
                master_in_reg <= writedata[1:0];
            end
        end
    end

    // ---------------- slice-three enable effects ----------------

    // remembered enable gives a one-cycle pulse when it is turned off
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            slice_en_d_reg <= 1'b0;
        end else begin
            slice_en_d_reg <= slice_en;
        end
    end

    // processors stay in low-power reset while the slice is off
    assign slice3_hold_reset = ~slice_en;
    // upper slice-three registers return to defaults on the falling edge
    assign slice3_reg_reset  = slice_en_d_reg & ~slice_en;
    assign slice3_cfg        = slice3_cfg_reg[6:0];

    // ---------------- bypass delay line ----------------

    logic [7:0]                      dly_mem [0:(1 << trib_irq_pkg::DLY_AW)-1];
    logic [trib_irq_pkg::DLY_AW-1:0] wr_ptr_reg;     // write position, one byte a cycle
    logic [trib_irq_pkg::DLY_AW-1:0] mark_ptr_reg;   // write position at incoming marker
    logic [trib_irq_pkg::DLY_AW-1:0] rd_ptr_reg;     // read position, stepping each cycle, realigned by outgoing marker
    logic [trib_irq_pkg::DLY_AW-1:0] rd_addr;        // read position this cycle
    logic [trib_irq_pkg::DLY_AW-1:0] mark_now;       // marker position, same-cycle case
    logic [7:0]                      out_data_reg;   // registered outgoing byte
    logic [7:0]                      out_data_next;  // selected outgoing byte
    logic                            bypass_slot;    // slice-three byte while disabled

    // a marker in this very cycle points at the byte being written now
    assign mark_now = incoming_frame_marker ? wr_ptr_reg : mark_ptr_reg;
    // the outgoing marker realigns reads, so delay follows marker spacing;
    // spacing beyond the line depth wraps, a limit of this small store
    assign rd_addr  = outgoing_frame_marker ? mark_now : rd_ptr_reg;

    // write every incoming byte; only slice-three slots are ever read back
    always_ff @(posedge sys_clk) begin
        dly_mem[wr_ptr_reg] <= in_data;
    end

    // write and read pointers step each cycle; markers reload the mark and read pointers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_ptr_reg   <= '0;
            mark_ptr_reg <= '0;
            rd_ptr_reg   <= '0;
        end else begin
            wr_ptr_reg   <= wr_ptr_reg + 1'b1;
            mark_ptr_reg <= mark_now;
            rd_ptr_reg   <= rd_addr + 1'b1;
        end
    end

    // while off, slice-three slots carry the delayed incoming bytes untouched
    assign bypass_slot   = ~slice_en & out_slot_slice3;
    assign out_data_next = bypass_slot ? dly_mem[rd_addr] : processed_data;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            out_data_reg <= 8'h00;
        end else begin
            out_data_reg <= out_data_next;
        end
    end

    assign out_data = out_data_reg;

    // ---------------- status sources ----------------

    logic [2:0] pp_pending;       // summary per payload processor
    logic [2:0] lom_live;         // live loss state per framer
    logic [2:0] lom_changed;      // sticky change flag per framer
    logic [2:0] lom_clear;        // read-clear per framer
    logic       ipi_reg;          // incoming_parity_error_flag
    logic       ipi_clear;        // read-clear of the parity flag
    logic [7:0] rd_snap_reg;      // read data as returned, drives the clears

    // processors already mask locally disabled sources, so the summary
    // mirrors their request; reading the summary has no side effect;
    // a slice held in reset cannot request
    assign pp_pending = payload_proc_src_pending & {slice_en, 2'h3};

    // only flags that software actually saw are cleared; a change landing
    // between capture and acceptance stays pending for the next read
    assign lom_clear = {3{rd_par_taken}} & rd_snap_reg[trib_irq_pkg::LOM_LSB +: 3];
    assign ipi_clear = rd_par_taken & rd_snap_reg[trib_irq_pkg::IPI_BIT];

    // one tracker per framer
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_lom
            multiframe_change_tracker u_track (
                .sys_clk (sys_clk),
                .rst     (rst),
                .loss_in (multiframe_loss_in[gi]),
                .clear   (lom_clear[gi]),
                .live    (lom_live[gi]),
                .changed (lom_changed[gi])
            );
        end
    endgenerate

    // concatenated mode: every slice follows the slice-one framer
    assign multiframe_align_lost = concat_mode ? {3{lom_live[0]}} : lom_live;

    // parity flag: a new mismatch beats a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ipi_reg <= 1'b0;
        end else begin
            ipi_reg <= parity_mismatch | (ipi_reg & ~ipi_clear);
        end
    end

    // ---------------- read data ----------------

    logic [7:0] rd_byte;          // selected register byte

    assign rd_byte =
        ~word_ok                                     ? 8'h00 :
        (reg_idx == trib_irq_pkg::IDX_SLICE3_CFG)    ? slice3_cfg_reg :
        (reg_idx == trib_irq_pkg::IDX_IRQ_ENABLE)    ? {2'h0, irq_en_reg} :
        (reg_idx == trib_irq_pkg::IDX_IRQ_STATUS)    ? {2'h0, lom_live, pp_pending} :
        (reg_idx == trib_irq_pkg::IDX_PARITY_LOM)    ? {ipi_reg, 1'b0, lom_changed, rsv_reg} :
        (reg_idx == trib_irq_pkg::IDX_MASTER_IN)     ? {6'h00, master_in_reg} :
                                                       8'h00;   // unmapped reads zero

    // read data loaded in the waiting cycle and held through acceptance
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_snap_reg <= 8'h00;
        end else if (rd_capture) begin
            rd_snap_reg <= rd_byte;
        end
    end

    assign readdata = {{(trib_irq_pkg::DATA_W-8){1'b0}}, rd_snap_reg};

    // ---------------- interrupt output ----------------

    logic [6:0] irq_src;          // every enabled, pending source
    logic       irq_out_n_reg;    // registered active-low request

    // processor enables gate only this output, never the status bits
    assign irq_src = {pp_pending  & pp_en,
                      lom_changed & lom_en,
                      ipi_reg     & parity_en};

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_out_n_reg <= 1'b1;
        end else begin
            irq_out_n_reg <= ~(|irq_src);
        end
    end

    assign irq_out_n = irq_out_n_reg;

endmodule // tributary_interrupt_aggregator

// *** shared/trib_irq_pkg.sv ***
package trib_irq_pkg;

    // avalon byte address width and register data width
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int REG_W  = 8;

    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_SLICE3_CFG   = 8'h06;  // slice-three configuration
    localparam logic [7:0] IDX_IRQ_ENABLE   = 8'h07;  // payload_and_multiframe_irq_enable
    localparam logic [7:0] IDX_IRQ_STATUS   = 8'h08;  // payload_irq_and_multiframe_status
    localparam logic [7:0] IDX_PARITY_LOM   = 8'h09;  // parity_and_multiframe_irq
    localparam logic [7:0] IDX_MASTER_IN    = 8'h10;  // master incoming configuration

    // field positions inside the byte-wide registers
    localparam int SLICE_EN_BIT = 7;  // slice_processing_enable
    localparam int PP_LSB       = 0;  // three payload processor bits
    localparam int LOM_LSB      = 3;  // three multiframe bits
    localparam int RSV_LSB      = 0;  // three reserved set-one bits
    localparam int IPI_BIT      = 7;  // incoming_parity_error_flag
    localparam int CONCAT_BIT   = 0;  // incoming_concat_mode
    localparam int IPE_BIT      = 1;  // incoming_parity_irq_enable

    // reset values
    localparam logic [7:0] SLICE3_CFG_RST = 8'h00;
    localparam logic [5:0] IRQ_EN_RST     = 6'h00;
    localparam logic [2:0] RSV_RST        = 3'h7;
    localparam logic [1:0] MASTER_IN_RST  = 2'h0;

    // bypass delay line address width; the line is 64 bytes deep
    localparam int DLY_AW = 6;

endpackage

// *** tb/tb.sv ***
// self-checking bench for the interrupt aggregator
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;                   // 250 MHz
    logic        rst = 1'b1;
    logic [9:0]  address = 10'h000;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0]  byteenable = 4'hF;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [2:0]  payload_proc_src_pending = 3'h0;
    logic [2:0]  multiframe_loss_in = 3'h0;
    logic        parity_mismatch = 1'b0;
    logic [7:0]  in_data = 8'h00;                  // free-running byte pattern
    logic        incoming_frame_marker = 1'b0;
    logic        outgoing_frame_marker = 1'b0;
    logic        out_slot_slice3 = 1'b0;
    logic [7:0]  processed_data = 8'hA5;           // differs from any bypassed byte
    logic [7:0]  out_data;
    logic        slice3_hold_reset;
    logic        slice3_reg_reset;
    logic [6:0]  slice3_cfg;
    logic [2:0]  multiframe_align_lost;
    logic        irq_out_n;
    logic [31:0] rd;                               // last read data
    int          n_fail = 0;
    int          num_checks = 0;
    int          cyc = 0;
    // register rows: optional write, then a read compared with exp
    typedef struct packed {logic wr; logic [7:0] idx; logic [7:0] wd; logic [7:0] exp;} row_s;
    row_s rows [10] = '{
        '{1'b0, 8'h06, 8'h00, 8'h00}, '{1'b0, 8'h07, 8'h00, 8'h00},
        '{1'b0, 8'h08, 8'h00, 8'h00}, '{1'b0, 8'h09, 8'h00, 8'h07},
        '{1'b0, 8'h10, 8'h00, 8'h00}, '{1'b1, 8'h05, 8'hFF, 8'h00},
        '{1'b1, 8'h07, 8'hFF, 8'h3F}, '{1'b1, 8'h09, 8'h00, 8'h00},
        '{1'b1, 8'h09, 8'h07, 8'h07}, // reserved bits put back to ones
        '{1'b1, 8'h06, 8'h7F, 8'h7F}  // mode bits reach the slice while it stays off
    };

    tributary_interrupt_aggregator uut (
        .sys_clk, .rst, .address, .read, .write, .writedata, .byteenable, .readdata,
        .waitrequest, .payload_proc_src_pending, .multiframe_loss_in, .parity_mismatch,
        .in_data, .incoming_frame_marker, .outgoing_frame_marker, .out_slot_slice3,
        .processed_data, .out_data, .slice3_hold_reset, .slice3_reg_reset, .slice3_cfg,
        .multiframe_align_lost, .irq_out_n
    );

    always #2 sys_clk = ~sys_clk;
    // incoming stream changes every cycle so a wrong delay shows
    always @(posedge sys_clk) in_data <= in_data + 8'h01;
    // watchdog against a hung handshake
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            finish_test();
        end
    end

    task finish_test;
        if (n_fail == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task check(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // request held until waitrequest is sampled low
    task bus_rd(input logic [7:0] idx);
        @(posedge sys_clk);
        read <= 1'b1;
        address <= {idx, 2'b00};
        do @(posedge sys_clk); while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
    endtask

    task bus_wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be = 4'hF);
        @(posedge sys_clk);
        write <= 1'b1;
        address <= {idx, 2'b00};
        writedata <= {24'h0, d};
        byteenable <= be;
        do @(posedge sys_clk); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask

    task rdc(input logic [7:0] idx, input logic [7:0] exp);
        bus_rd(idx);
        check($sformatf("reg %h", idx), exp, rd[7:0]);
    endtask

    task settle(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    // irq is registered: allow the source and the flop to land
    task chk_irq(input logic e);
        settle(3);
        check("irq_out_n", {7'h0, e}, {7'h0, irq_out_n});
    endtask

    initial begin
        int dly;
        logic [7:0] exp;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        settle(1);
        check("hold", 8'h01, {7'h0, slice3_hold_reset});
        check("irq_out_n", 8'h01, {7'h0, irq_out_n});
        foreach (rows[i]) begin
            if (rows[i].wr)
                bus_wr(rows[i].idx, rows[i].wd);
            rdc(rows[i].idx, rows[i].exp);
        end
        bus_wr(8'h07, 8'h00); // rows left every processor and multiframe enable set; clear them first
        bus_wr(8'h07, 8'h3F, 4'hE);
        rdc(8'h07, 8'h00); // write without low byte lane ignored
        // payload summaries: enable gates only the output
        bus_wr(8'h06, 8'h80);
        @(posedge sys_clk) payload_proc_src_pending <= 3'h7;
        chk_irq(1'b1);
        rdc(8'h08, 8'h07);
        bus_wr(8'h07, 8'h04);
        chk_irq(1'b0);
        rdc(8'h08, 8'h07);
        chk_irq(1'b0);
        bus_wr(8'h06, 8'h00);
        chk_irq(1'b1);
        rdc(8'h08, 8'h03);
        @(posedge sys_clk) payload_proc_src_pending <= 3'h0;
        rdc(8'h08, 8'h00);
        bus_wr(8'h07, 8'h00);
        // framer changes while masked, then enabled
        @(posedge sys_clk) multiframe_loss_in <= 3'h2;
        chk_irq(1'b1);
        rdc(8'h08, 8'h10);
        rdc(8'h09, 8'h17);
        rdc(8'h09, 8'h07);
        bus_wr(8'h07, 8'h08);
        @(posedge sys_clk) multiframe_loss_in <= 3'h3;
        chk_irq(1'b0);
        rdc(8'h09, 8'h0F);
        chk_irq(1'b1);
        bus_wr(8'h10, 8'h01); // slice two/three multiframe enables stay zero
        settle(1);
        check("align", 8'h07, {5'h0, multiframe_align_lost});
        @(posedge sys_clk) multiframe_loss_in <= 3'h2;
        chk_irq(1'b0);
        check("align", 8'h00, {5'h0, multiframe_align_lost});
        rdc(8'h09, 8'h0F);
        bus_wr(8'h10, 8'h00);
        settle(1);
        check("align", 8'h02, {5'h0, multiframe_align_lost});
        bus_wr(8'h07, 8'h00);
        // parity flag, masked then enabled
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk) parity_mismatch <= 1'b1;
            @(posedge sys_clk) parity_mismatch <= 1'b0;
            chk_irq(k == 0);
            rdc(8'h09, 8'h87);
            chk_irq(1'b1);
            rdc(8'h09, 8'h07);
            bus_wr(8'h10, 8'h02);
        end
        // bypass delay set by marker separation
        for (int k = 0; k < 2; k++) begin
            dly = (k == 0) ? 5 : 12;
            @(posedge sys_clk);
            incoming_frame_marker <= 1'b1;
            exp = in_data + 8'h01;
            @(posedge sys_clk) incoming_frame_marker <= 1'b0;
            repeat (dly - 1) @(posedge sys_clk);
            outgoing_frame_marker <= 1'b1;
            out_slot_slice3 <= 1'b1;
            @(posedge sys_clk) outgoing_frame_marker <= 1'b0;
            @(negedge sys_clk) check("bypass", exp, out_data);
            @(negedge sys_clk) check("bypass next", exp + 8'h01, out_data);
            @(posedge sys_clk) out_slot_slice3 <= 1'b0;
        end
        bus_wr(8'h06, 8'h80);
        @(posedge sys_clk) out_slot_slice3 <= 1'b1;
        settle(1);
        check("processed", 8'hA5, out_data);
        check("hold", 8'h00, {7'h0, slice3_hold_reset});
        @(posedge sys_clk) out_slot_slice3 <= 1'b0;
        bus_wr(8'h06, 8'h00); // disable pulses the register reset
        @(negedge sys_clk) check("reg reset", 8'h01, {7'h0, slice3_reg_reset});
        settle(1);
        check("reg reset end", 8'h00, {7'h0, slice3_reg_reset});
        check("hold", 8'h01, {7'h0, slice3_hold_reset});
        // reset in mid-run returns the enables to zero
        bus_wr(8'h07, 8'h3F);
        @(posedge sys_clk) rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rdc(8'h07, 8'h00);
        finish_test();
    end
endmodule // tb

// *** tb/trib_irq_props.sv ***
// protocol and flag checks on the aggregator ports
module trib_irq_props (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic [9:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic [2:0]  multiframe_loss_in,
    input wire logic        parity_mismatch,
    input wire logic        slice3_hold_reset,
    input wire logic        slice3_reg_reset,
    input wire logic [6:0]  slice3_cfg
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // accepted transfers to the registers of interest
    wire rd_acc = read && !waitrequest;
    wire rd08   = rd_acc && address == 10'h020;
    wire rd09   = rd_acc && address == 10'h024;
    wire wr06   = write && !waitrequest && address == 10'h018 && byteenable[0];

    a_one_wait: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
        else $error("bus answer not after exactly one wait state");
    a_upper_zero: assert property (rd_acc |-> readdata[31:8] == 24'h0)
        else $error("read data upper bytes not zero");
    a_cfg_write: assert property (
        wr06 |=> slice3_hold_reset == !$past(writedata[7]) && slice3_cfg == $past(writedata[6:0]))
        else $error("slice three hold or config does not follow write");
    a_reg_reset_edge: assert property ($rose(slice3_hold_reset) |-> ##[0:1] slice3_reg_reset)
        else $error("no register reset pulse on disable");
    a_reg_reset_pulse: assert property (
        slice3_reg_reset |-> slice3_hold_reset ##1 !slice3_reg_reset)
        else $error("register reset pulse wrong");
    a_live_mirror: assert property (
        rd08 |-> readdata[5:3] == $past(multiframe_loss_in, 2))
        else $error("live loss bits do not follow framers");
    // a change two cycles before the accept must be in the returned flags
    a_change_sets: assert property (rd09 |->
        (readdata[5:3] & ($past(multiframe_loss_in, 2) ^ $past(multiframe_loss_in, 3)))
        == ($past(multiframe_loss_in, 2) ^ $past(multiframe_loss_in, 3)))
        else $error("change flag missing after framer change");
    // quiet framers around a read leave nothing for the next read
    a_change_clear: assert property (
        rd09 && $stable(multiframe_loss_in) && $past(multiframe_loss_in) ==
        $past(multiframe_loss_in, 2) ##1 $stable(multiframe_loss_in) ##2 rd09
        |-> readdata[5:3] == 3'h0)
        else $error("change flags not cleared by read");
    a_parity_sets: assert property (parity_mismatch ##2 rd09 |-> readdata[7])
        else $error("parity flag not set");
    a_parity_clear: assert property (
        rd09 && readdata[7] && !parity_mismatch && !$past(parity_mismatch)
        ##1 !parity_mismatch ##2 rd09 |-> !readdata[7])
        else $error("parity flag not cleared by read");

    c_parity: cover property (rd09 && readdata[7]);
    c_change: cover property (rd09 && readdata[5:3] != 3'h0);
    c_reg_reset: cover property (slice3_reg_reset);
endmodule // trib_irq_props

bind tributary_interrupt_aggregator trib_irq_props chk (
    .sys_clk, .rst, .address, .read, .write, .writedata, .byteenable, .readdata,
    .waitrequest, .multiframe_loss_in, .parity_mismatch, .slice3_hold_reset,
    .slice3_reg_reset, .slice3_cfg
);
